//--- hw/crf_register_frame.sv
// Purpose: Register frame decoder and first registers of a serial converter register bank
// Assumes: Host keeps frame select high for at least 3 core clocks between frames
// Notes:   Read data for a read frame is shifted out during the following frame
//
// Functional notes
// RULE1: Frame bit 31 set means read request, clear means write request.
// RULE2: Frames to address 00h change no state; host sends zero payload.
// RULE3: Address 01h holds the MSB-aligned straight binary code, readable and writable.
// RULE4: Code is 20, 18 or 16 bits; unused low field bits stay zero.
// RULE5: After reset the idle command and output code registers hold zero.
// RULE6: After reset setup_first_reg at 02h reads back 004c80h.
// RULE7: Host gives exactly 32 serial clock pulses while frame select is low.
// RULE8: Frame bits 3:0 are ignored on writes and returned as zero on reads.
`timescale 1ns/1ps

module crf_register_frame #(
  parameter int CODE_BITS = 20
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Serial pins
  input wire logic sclk_in,
  input wire logic sync_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  // Converter side
  output logic [19:0] code_out,
  output logic code_load_out,
  output logic [23:0] setup_first_out,
  output logic frame_drop_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Ones over the code bits this variant really has, zeros below
  function automatic logic [19:0] code_mask(input int bits);
    logic [19:0] m;
    m = 20'h00000;
    for (int i = 0; i < crf_pkg::CODE_W; i++)
    begin
      m[i] = (i >= crf_pkg::CODE_W - bits);
    end
    return m;
  endfunction

  function automatic logic [23:0] read_field(input logic [6:0] addr, input logic [19:0] code,
                                             input logic [23:0] setup);
    logic [23:0] f;
    f = 24'h000000;
    if (addr == crf_pkg::ADDR_OUTPUT_CODE)
    begin
      f = {code, crf_pkg::PAD_ZERO};
    end
    else if (addr == crf_pkg::ADDR_SETUP_FIRST)
    begin
      f = setup;
    end
    return f;
  endfunction

  localparam logic [19:0] CODE_MASK = code_mask(CODE_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    crf_pkg::crf_fsm_t fsm;
    logic [31:0] reply;
    logic [19:0] code;
    logic [23:0] setup;
    logic code_load;
    logic fresh;
  } crf_frame_state_t;

  crf_frame_state_t state_reg;
  crf_frame_state_t state_next;

  logic [31:0] frame_word;
  logic frame_done;
  logic frame_drop;
  logic frame_rd;
  logic [6:0] frame_addr;
  logic [19:0] frame_pay;
  logic reply_load;

  assign frame_rd = frame_word[crf_pkg::RW_BIT];
  assign frame_addr = frame_word[crf_pkg::ADDR_MSB:crf_pkg::ADDR_LSB];
  // Padding bits 3:0 are never looked at (see RULE8)
  assign frame_pay = frame_word[crf_pkg::PAY_MSB:crf_pkg::PAY_LSB];
  assign reply_load = (state_reg.fsm == crf_pkg::CRF_ST_REPLY);

  crf_frame_shift u_shift (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .sclk_in(sclk_in),
    .sync_n_in(sync_n_in),
    .sdi_in(sdi_in),
    .sdo_out(sdo_out),
    .sdo_en_in(state_reg.setup[crf_pkg::SETUP_SDO_EN_BIT]),
    .load_in(reply_load),
    .load_word_in(state_reg.reply),
    .frame_word_out(frame_word),
    .frame_done_out(frame_done),
    .frame_drop_out(frame_drop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode

  always_comb
  begin
    state_next = state_reg;
    state_next.code_load = 1'b0;
    state_next.fresh = 1'b0;
    unique case (state_reg.fsm)
      crf_pkg::CRF_ST_IDLE:
      begin
        if (frame_done)
        begin
          if (frame_rd)
          begin
            // Reads only capture a reply; no register changes (see RULE1)
            state_next.reply = {1'b1, frame_addr, read_field(frame_addr, state_reg.code, state_reg.setup)};
            state_next.reply[3:0] = crf_pkg::PAD_ZERO; // see RULE8
            state_next.fsm = crf_pkg::CRF_ST_REPLY;
          end
          else if (frame_addr == crf_pkg::ADDR_OUTPUT_CODE)
          begin
            state_next.code = frame_pay & CODE_MASK; // see RULE3, see RULE4
            state_next.code_load = 1'b1;
          end
          else if (frame_addr == crf_pkg::ADDR_SETUP_FIRST)
          begin
            state_next.setup = (state_reg.setup & ~crf_pkg::SETUP_FIRST_WMASK)
                             | ({frame_pay, crf_pkg::PAD_ZERO} & crf_pkg::SETUP_FIRST_WMASK);
          end
          // Idle command and unmapped addresses fall through untouched (see RULE2)
        end
      end
      crf_pkg::CRF_ST_REPLY:
      begin
        state_next.fsm = crf_pkg::CRF_ST_IDLE;
      end
      default:
      begin
        state_next.fsm = crf_pkg::CRF_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      // see RULE5, see RULE6
      state_reg <= '{fsm: crf_pkg::CRF_ST_IDLE, reply: 32'h00000000, code: crf_pkg::OUTPUT_CODE_RST,
                     setup: crf_pkg::SETUP_FIRST_RST, code_load: 1'b0, fresh: 1'b1};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign code_out = state_reg.code;
  assign code_load_out = state_reg.code_load;
  assign setup_first_out = state_reg.setup;
  assign frame_drop_out = frame_drop;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking crf_cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_read_req;
    frame_done && frame_rd && state_reg.fsm == crf_pkg::CRF_ST_IDLE;
  endsequence

  sequence s_code_write;
    frame_done && !frame_rd && frame_addr == crf_pkg::ADDR_OUTPUT_CODE
      && state_reg.fsm == crf_pkg::CRF_ST_IDLE;
  endsequence

  a_read_no_change: assert property ( // see RULE1
    s_read_req |=> $stable(state_reg.code) && $stable(state_reg.setup) && !code_load_out)
    else $error("read frame changed register state");

  a_write_takes_code: assert property ( // see RULE3
    s_code_write |=> code_load_out && code_out == ($past(frame_pay) & CODE_MASK))
    else $error("code write not taken");

  a_idle_cmd_inert: assert property ( // see RULE2
    frame_done && frame_addr == crf_pkg::ADDR_IDLE_CMD
      |=> $stable(state_reg.code) && $stable(state_reg.setup) && !code_load_out)
    else $error("idle command changed state");

  a_code_readback: assert property ( // see RULE3
    s_read_req ##0 (frame_addr == crf_pkg::ADDR_OUTPUT_CODE)
      |=> reply_load && state_reg.reply[crf_pkg::PAY_MSB:crf_pkg::PAY_LSB] == code_out)
    else $error("code readback word wrong");

  a_variant_low_zero: assert property ( // see RULE4
    (code_out & ~CODE_MASK) == 20'h00000)
    else $error("unused code bits not zero");

  a_reset_code_zero: assert property ( // see RULE5
    state_reg.fresh |-> code_out == crf_pkg::OUTPUT_CODE_RST && !code_load_out)
    else $error("code not zero after reset");

  a_reset_setup_val: assert property ( // see RULE6
    state_reg.fresh |-> setup_first_out == crf_pkg::SETUP_FIRST_RST)
    else $error("setup register reset value wrong");

  a_reply_pad_zero: assert property ( // see RULE8
    s_read_req |=> reply_load && state_reg.reply[3:0] == crf_pkg::PAD_ZERO ##1 !reply_load)
    else $error("reply padding not zero");

endmodule

//--- hw/crf_pkg.sv
// Purpose: Shared constants and types for the serial register frame block
// Assumes: 32-bit frames, MSB first, one device per frame select
// Notes:   Frame layout is {rw, address[6:0], payload[23:0]}; payload bits 3:0 are padding

package crf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int FRAME_BITS = 32;
  localparam int RW_BIT = 31;
  localparam int ADDR_MSB = 30;
  localparam int ADDR_LSB = 24;
  localparam int PAY_MSB = 23;
  localparam int PAY_LSB = 4;
  localparam int CODE_W = 20;
  localparam logic [5:0] CNT_FULL = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h21;
  localparam logic [3:0] PAD_ZERO = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [6:0] ADDR_IDLE_CMD = 7'h00;
  localparam logic [6:0] ADDR_OUTPUT_CODE = 7'h01;
  localparam logic [6:0] ADDR_SETUP_FIRST = 7'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and field positions
  localparam logic [19:0] OUTPUT_CODE_RST = 20'h00000;
  localparam logic [23:0] SETUP_FIRST_RST = 24'h004c80;
  // Writable fields of setup_first_reg; all other bits read back as stored zero
  localparam logic [23:0] SETUP_FIRST_WMASK = 24'h8c7fd0;
  localparam int SETUP_SDO_EN_BIT = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Frame handling states
  typedef enum logic [1:0] {
    CRF_ST_IDLE = 2'b01,
    CRF_ST_REPLY = 2'b10
  } crf_fsm_t;

endpackage

//--- hw/crf_frame_shift.sv
// Purpose: Serial frame shifter: samples the link pins and assembles 32-bit frames
// Assumes: Link pins are synchronous to core_clk_in and at least 4x slower
// Notes:   Data in on falling serial clock, data out changes on rising serial clock
`timescale 1ns/1ps

module crf_frame_shift (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Serial pins
  input wire logic sclk_in,
  input wire logic sync_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  // Readback loading
  input wire logic sdo_en_in,
  input wire logic load_in,
  input wire logic [31:0] load_word_in,
  // Assembled frame
  output logic [31:0] frame_word_out,
  output logic frame_done_out,
  output logic frame_drop_out
);

  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic [5:0] cnt;
    logic [31:0] shin;
    logic [31:0] shout;
    logic done;
    logic drop;
    logic sdo;
  } crf_shift_state_t;

  crf_shift_state_t state_reg;
  crf_shift_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.drop = 1'b0;
    state_next.sclk = sclk_in;
    state_next.sync_n = sync_n_in;
    if (state_reg.sync_n && !sync_n_in)
    begin
      state_next.cnt = 6'h00;
    end
    else if (!sync_n_in)
    begin
      if (state_reg.sclk && !sclk_in)
      begin
        state_next.shin = {state_reg.shin[30:0], sdi_in};
        // Saturate so an overlong frame is still recognised as wrong
        if (state_reg.cnt != crf_pkg::CNT_SAT)
        begin
          state_next.cnt = state_reg.cnt + 6'h01;
        end
      end
      else if (!state_reg.sclk && sclk_in && state_reg.cnt != 6'h00)
      begin
        // No shift before the first falling edge, so the MSB is seen by the host
        state_next.shout = {state_reg.shout[30:0], 1'b0};
      end
    end
    else if (!state_reg.sync_n)
    begin
      // Frame select rose: only a frame of exactly 32 pulses counts
      if (state_reg.cnt == crf_pkg::CNT_FULL)
      begin
        state_next.done = 1'b1;
      end
      else
      begin
        state_next.drop = 1'b1;
      end
    end
    if (load_in)
    begin
      state_next.shout = load_word_in;
    end
    state_next.sdo = sdo_en_in & state_next.shout[31];
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg <= '{sclk: 1'b0, sync_n: 1'b1, cnt: 6'h00, shin: 32'h00000000,
                     shout: 32'h00000000, done: 1'b0, drop: 1'b0, sdo: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign frame_word_out = state_reg.shin;
  assign frame_done_out = state_reg.done;
  assign frame_drop_out = state_reg.drop;
  assign sdo_out = state_reg.sdo;

endmodule

//--- bench/crf_host_model.sv
// Purpose: Host serial master for the register frame block
// Assumes: Link pins driven just after rising core edges
// Notes: Link clock idles low; data line inverted once released
`timescale 1ns/1ps

module crf_host_model (
  // Clock
  input wire logic core_clk_in,
  // Serial pins
  output logic sclk_out,
  output logic sync_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  initial
  begin
    sclk_out = 1'b0;
    sync_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame; a pulse count other than 32 only on command
  task automatic xfer(input logic [31:0] tx, input int pulses, output logic [31:0] rx);
    rx = 32'h0;
    sync_n_out <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    for (int i = 0; i < pulses; i++)
    begin
      sdi_out <= tx[31 - (i % 32)];
      sclk_out <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      rx = {rx[30:0], sdo_in};
      sclk_out <= 1'b0;
      repeat (3) @(posedge core_clk_in);
    end
    // Released line must not look like held data
    sdi_out <= ~sdi_out;
    sync_n_out <= 1'b1;
    repeat (6) @(posedge core_clk_in);
  endtask
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench for the register frame block
// Assumes: 18-bit code variant
// Notes: Read replies are checked on the frame after the read
`timescale 1ns/1ps

module testbench;
  localparam int CB = 18;
  localparam logic [23:0] WMASK = 24'h8c7fd0;
  localparam logic [19:0] CMASK = 20'hfffff << (20 - CB);
  logic core_clk_in;
  logic arst_n_in;
  logic sclk;
  logic sync_n;
  logic sdi;
  logic sdo_out;
  logic [19:0] code_out;
  logic code_load_out;
  logic [23:0] setup_first_out;
  logic frame_drop_out;
  int fail_count;
  int cmp_count;
  int loads;
  int drops;
  int loads_m;
  int drops_m;
  bit skip;
  logic [31:0] seed;
  logic [31:0] w;
  logic [31:0] reply_m;
  logic [19:0] code_m;
  logic [23:0] setup_m;

  crf_register_frame #(.CODE_BITS(CB)) i_dut (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .sclk_in(sclk),
    .sync_n_in(sync_n),
    .sdi_in(sdi),
    .sdo_out(sdo_out),
    .code_out(code_out),
    .code_load_out(code_load_out),
    .setup_first_out(setup_first_out),
    .frame_drop_out(frame_drop_out)
  );

  crf_host_model i_host (
    .core_clk_in(core_clk_in),
    .sclk_out(sclk),
    .sync_n_out(sync_n),
    .sdi_out(sdi),
    .sdo_in(sdo_out)
  );

  initial
  begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in)
  begin
    if (code_load_out === 1'b1) loads++;
    if (frame_drop_out === 1'b1) drops++;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp, input string what);
    cmp_count++;
    if (got != exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s count %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Frame plus model update; a short or long frame is dropped whole
  task automatic frame(input logic rw, input logic [6:0] addr, input logic [23:0] pay, input int n);
    logic [31:0] rx;
    // This task sends the padding bits as zero, whatever the caller passes
    i_host.xfer({rw, addr, pay[23:4], 4'h0}, n, rx);
    if (n == 32 && !skip) check_word(rx, reply_m, "reply");
    skip = (n != 32);
    reply_m = 32'h0;
    if (n != 32)
      drops_m++;
    else if (rw)
    begin
      reply_m = {1'b1, addr, 24'h0};
      if (addr == 7'h01) reply_m[23:0] = {code_m, 4'h0};
      if (addr == 7'h02) reply_m[23:0] = setup_m;
    end
    else if (addr == 7'h01)
    begin
      code_m = pay[23:4] & CMASK;
      loads_m++;
    end
    else if (addr == 7'h02)
      setup_m = (setup_m & ~WMASK) | (pay & WMASK);
    check_word({12'h0, code_out}, {12'h0, code_m}, "code");
    check_word({8'h0, setup_first_out}, {8'h0, setup_m}, "setup");
    check_count(loads, loads_m, "load");
    check_count(drops, drops_m, "drop");
  endtask

  initial
  begin
    arst_n_in = 1'b0;
    seed = 32'hebc4;
    code_m = 20'h0;
    setup_m = 24'h004c80;
    reply_m = 32'h0;
    repeat (12) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    check_word({12'h0, code_out}, 32'h0, "reset code");
    check_word({8'h0, setup_first_out}, 32'h004c80, "reset setup");
    frame(1'b1, 7'h01, 24'h0, 32);
    frame(1'b1, 7'h02, 24'h0, 32);
    frame(1'b1, 7'h00, 24'h0, 32);
    for (int i = 0; i < 12; i++)
    begin
      w = rnd();
      // Random code bits; the frame task zeroes the padding
      frame(1'b0, 7'h01, w[23:0], 32);
      frame(1'b1, 7'h01, 24'h0, 32);
    end
    for (int i = 0; i < 6; i++)
    begin
      w = rnd() | 32'h800;
      frame(1'b0, 7'h02, w[23:0], 32);
      frame(1'b1, 7'h02, 24'h0, 32);
    end
    frame(1'b0, 7'h00, 24'h0, 32);
    w = rnd();
    frame(1'b0, 7'h05, w[23:0], 32);
    frame(1'b1, 7'h05, 24'h0, 32);
    // Full frame so the unmapped read reply is compared before the bad frames
    frame(1'b1, 7'h00, 24'h0, 32);
    frame(1'b0, 7'h01, w[23:0], 31);
    frame(1'b0, 7'h01, ~w[23:0], 33);
    frame(1'b1, 7'h01, 24'h0, 32);
    frame(1'b1, 7'h02, 24'h0, 32);
    test_done();
  end

  initial
  begin
    #200000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
